// ===== shared/ctao_defs.svh
`ifndef CTAO_DEFS_SVH
`define CTAO_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CTAO_A_CTRL 8'h00
`define CTAO_A_SETUP 8'h04
`define CTAO_A_CMD 8'h08
`define CTAO_A_ENTRY_A 8'h0c
`define CTAO_A_ENTRY_P 8'h10
`define CTAO_A_RD_IDX 8'h14
`define CTAO_A_RD_A 8'h18
`define CTAO_A_RD_P 8'h1c
`define CTAO_A_COUNT 8'h20
`define CTAO_A_TIMER 8'h24
`define CTAO_A_HOLD0 8'h28
`define CTAO_A_HOLD1 8'h2c
`define CTAO_A_LINK 8'h30
`define CTAO_A_TX 8'h34
`define CTAO_A_IRQ_ST 8'h38
`define CTAO_A_IRQ_EN 8'h3c
`define CTAO_A_IRQ_CLR 8'h40
// ----------------------------------------
// Fields
// ----------------------------------------
`define CTAO_B_PROG 0
`define CTAO_B_TEACH 0
`define CTAO_B_ENC 1
`define CTAO_B_STORE 8
`define CTAO_F_CMD 2:0
`define CTAO_F_ERR 7:0
`define CTAO_F_PCT 7:0
`define CTAO_F_RD_IDX 4:0
`define CTAO_B_RD_BUF 4
`define CTAO_F_WCNT 4:0
`define CTAO_F_BCNT 12:8
`define CTAO_F_TMR_MULT 13:0
`define CTAO_F_TMR_IDX 18:16
`define CTAO_B_TMR_EN 20
`define CTAO_F_HOLD1 15:0
`define CTAO_F_IRQ 3:0
`define CTAO_B_TX_BUSY 0
`define CTAO_F_CHAR 7:0
// ----------------------------------------
// Commands, codes, limits
// ----------------------------------------
`define CTAO_CMD_CM 3'h1
`define CTAO_CMD_WM 3'h2
`define CTAO_CMD_APPEND 3'h3
`define CTAO_CMD_SAVE 3'h4
`define CTAO_ERR_NONE 8'h00
`define CTAO_ERR_DATA 8'h66
`define CTAO_ERR_MULTI 8'h68
`define CTAO_ERR_MEM 8'h6d
`define CTAO_ERR_NOW 8'h6e
`define CTAO_ERR_EMPTY 8'h70
`define CTAO_ERR_BUF_EMPTY 8'h71
`define CTAO_DEPTH_CNT 5'h10
`define CTAO_PCT_MIN 8'h9c
`define CTAO_PCT_MAX 8'h64
`define CTAO_ANA_LO 6'h33
`define CTAO_ANA_HI 6'h36
`define CTAO_TOUT_LO 6'h01
`define CTAO_TOUT_HI 6'h08
`define CTAO_TMR_MIN 14'h0001
`define CTAO_TMR_MAX 14'h270f
`define CTAO_TICK_MS 10
`define CTAO_CLK_KHZ 25000
// Data bits 7, odd parity, 1 stop bit, flow control on
`define CTAO_LINK_CFG 32'h00000167
`define CTAO_TEACH_RST 1'b1
`define CTAO_ENC_RST 1'b0
`define CTAO_EV_DONE 0
`define CTAO_EV_ERR 1
`define CTAO_EV_TMR 2
`define CTAO_EV_TX 3
`define CTAO_CH_O 8'h4f
`define CTAO_CH_K 8'h4b
`define CTAO_CH_CR 8'h0d
`define CTAO_CH_LF 8'h0a
`define CTAO_CH_ETX 8'h03
`define CTAO_OK_LAST 3'h4
`endif

// ===== shared/ctao_pkg.sv
package ctao_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ECHO = 2'b01,
        TX_OK = 2'b10
    } ctao_tx_type;

    typedef struct packed {
        logic [10:0] stop;
        logic [10:0] start;
        logic [3:0] cam;
        logic [5:0] out;
        logic [7:0] pct;
    } ctao_entry_type;

    typedef struct packed {
        logic prog;
        logic teach;
        logic enc_lin;
        logic store_pend;
        logic nv_store;
        logic [7:0] err_code;
        ctao_entry_type [15:0] wrk;
        ctao_entry_type [15:0] bufm;
        logic [4:0] wcnt;
        logic [4:0] bcnt;
        logic [31:0] ent_a;
        logic [7:0] ent_p;
        logic [4:0] rd_idx;
        logic [7:0][13:0] tmr_mult;
        logic [7:0] tmr_en;
        logic [2:0] tmr_sel;
        logic [7:0][13:0] tcnt;
        logic [7:0] hold;
        logic [7:0] win_q;
        logic [7:0] sw_out;
        logic [17:0] pre;
        logic [5:0][7:0] hoff;
        logic [3:0] irq_st;
        logic [3:0] irq_en;
        ctao_tx_type tx_st;
        logic [7:0] tx_ch;
        logic [2:0] tx_idx;
        logic [7:0] tx_data;
        logic tx_valid;
    } ctao_state_type;
endpackage : ctao_pkg

// ===== verilog/ctao_top.sv
`include "ctao_defs.svh"
module ctao_top #(
    parameter int TICK_CYCLES = `CTAO_TICK_MS * `CTAO_CLK_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] cam_win,
    output logic [7:0] sw_out,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic teach_en,
    output logic enc_linear,
    output logic store_led,
    output logic nv_store,
    output logic irq
);
    ctao_pkg::ctao_state_type s_ff;
    ctao_pkg::ctao_state_type nxt_s;
    ctao_pkg::ctao_entry_type ent;
    ctao_pkg::ctao_entry_type rd_ent;
    logic acc;
    logic wr;
    logic busy;
    logic tick;
    logic map_ok;
    logic is_ana;
    logic is_tout;
    logic pct_ok;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [7:0] err;
    logic [13:0] mult;

    function automatic logic [7:0] ok_char(input logic [2:0] idx);
        unique case (idx)
            3'h0: ok_char = `CTAO_CH_O;
            3'h1: ok_char = `CTAO_CH_K;
            3'h2: ok_char = `CTAO_CH_CR;
            3'h3: ok_char = `CTAO_CH_LF;
            default: ok_char = `CTAO_CH_ETX;
        endcase
    endfunction : ok_char

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // A character write stalls while the echo engine is busy
    assign busy = s_ff.tx_st != ctao_pkg::TX_IDLE;
    assign pready = ce & ~(psel & pwrite & (paddr == `CTAO_A_TX) & busy);
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign pslverr = acc & ~map_ok;

    assign ent = {s_ff.ent_a, s_ff.ent_p};
    assign is_ana = (ent.out >= `CTAO_ANA_LO) && (ent.out <= `CTAO_ANA_HI);
    assign is_tout = (ent.out >= `CTAO_TOUT_LO) && (ent.out <= `CTAO_TOUT_HI);
    assign pct_ok = ($signed(ent.pct) >= $signed(`CTAO_PCT_MIN)) && ($signed(ent.pct) <= $signed(`CTAO_PCT_MAX));
    assign mult = pwdata[`CTAO_F_TMR_MULT];

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rd_ent = s_ff.rd_idx[`CTAO_B_RD_BUF] ? s_ff.bufm[s_ff.rd_idx[3:0]] : s_ff.wrk[s_ff.rd_idx[3:0]];
        prdata = '0;
        map_ok = 1'b1;
        unique case (paddr)
            `CTAO_A_CTRL: prdata[`CTAO_B_PROG] = s_ff.prog;
            `CTAO_A_SETUP: begin
                prdata[`CTAO_B_TEACH] = s_ff.teach;
                prdata[`CTAO_B_ENC] = s_ff.enc_lin;
                prdata[`CTAO_B_STORE] = s_ff.store_pend;
            end
            `CTAO_A_CMD: prdata[`CTAO_F_ERR] = s_ff.err_code;
            `CTAO_A_ENTRY_A: prdata = s_ff.ent_a;
            `CTAO_A_ENTRY_P: prdata[`CTAO_F_PCT] = s_ff.ent_p;
            `CTAO_A_RD_IDX: prdata[`CTAO_F_RD_IDX] = s_ff.rd_idx;
            `CTAO_A_RD_A: prdata = {rd_ent.stop, rd_ent.start, rd_ent.cam, rd_ent.out};
            `CTAO_A_RD_P: prdata = {{24{rd_ent.pct[7]}}, rd_ent.pct};
            `CTAO_A_COUNT: begin
                prdata[`CTAO_F_WCNT] = s_ff.wcnt;
                prdata[`CTAO_F_BCNT] = s_ff.bcnt;
            end
            `CTAO_A_TIMER: begin
                prdata[`CTAO_F_TMR_MULT] = s_ff.tmr_mult[s_ff.tmr_sel];
                prdata[`CTAO_F_TMR_IDX] = s_ff.tmr_sel;
                prdata[`CTAO_B_TMR_EN] = s_ff.tmr_en[s_ff.tmr_sel];
            end
            `CTAO_A_HOLD0: prdata = s_ff.hoff[3:0];
            `CTAO_A_HOLD1: prdata[`CTAO_F_HOLD1] = s_ff.hoff[5:4];
            `CTAO_A_LINK: prdata = `CTAO_LINK_CFG;
            `CTAO_A_TX: prdata[`CTAO_B_TX_BUSY] = busy;
            `CTAO_A_IRQ_ST: prdata[`CTAO_F_IRQ] = s_ff.irq_st;
            `CTAO_A_IRQ_EN: prdata[`CTAO_F_IRQ] = s_ff.irq_en;
            `CTAO_A_IRQ_CLR: prdata = '0;
            default: map_ok = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.nv_store = 1'b0;
        ev = '0;
        clr = '0;
        err = `CTAO_ERR_NONE;
        // Shared prescaler: first tick of a delay may be partial
        tick = s_ff.pre == 18'(TICK_CYCLES - 1);
        nxt_s.pre = tick ? '0 : s_ff.pre + 18'h1;
        for (int i = 0; i < 8; i++) begin
            nxt_s.win_q[i] = cam_win[i];
            if (cam_win[i]) begin
                nxt_s.hold[i] = 1'b0;
                nxt_s.tcnt[i] = '0;
            end else if (s_ff.win_q[i] && s_ff.tmr_en[i]) begin
                nxt_s.hold[i] = 1'b1;
                nxt_s.tcnt[i] = '0;
            end else if (s_ff.hold[i] && tick) begin
                nxt_s.tcnt[i] = s_ff.tcnt[i] + 14'h1;
                if (s_ff.tcnt[i] + 14'h1 >= s_ff.tmr_mult[i]) begin
                    nxt_s.hold[i] = 1'b0;
                    ev[`CTAO_EV_TMR] = 1'b1;
                end
            end
            nxt_s.sw_out[i] = cam_win[i] | nxt_s.hold[i];
        end
        // Echo engine
        unique case (s_ff.tx_st)
            ctao_pkg::TX_IDLE: ;
            ctao_pkg::TX_ECHO: begin
                if (tx_ready) begin
                    if (s_ff.tx_ch == `CTAO_CH_LF) begin
                        nxt_s.tx_st = ctao_pkg::TX_OK;
                        nxt_s.tx_idx = '0;
                        nxt_s.tx_data = ok_char(3'h0);
                    end else begin
                        nxt_s.tx_st = ctao_pkg::TX_IDLE;
                        nxt_s.tx_valid = 1'b0;
                        ev[`CTAO_EV_TX] = 1'b1;
                    end
                end
            end
            ctao_pkg::TX_OK: begin
                if (tx_ready) begin
                    if (s_ff.tx_idx == `CTAO_OK_LAST) begin
                        nxt_s.tx_st = ctao_pkg::TX_IDLE;
                        nxt_s.tx_valid = 1'b0;
                        ev[`CTAO_EV_TX] = 1'b1;
                    end else begin
                        nxt_s.tx_idx = s_ff.tx_idx + 3'h1;
                        nxt_s.tx_data = ok_char(s_ff.tx_idx + 3'h1);
                    end
                end
            end
            default: nxt_s.tx_st = ctao_pkg::TX_IDLE;
        endcase
        if (wr) begin
            unique case (paddr)
                `CTAO_A_CTRL: begin
                    // Leaving programming mode commits pending setup
                    if (s_ff.prog && !pwdata[`CTAO_B_PROG] && s_ff.store_pend) begin
                        nxt_s.store_pend = 1'b0;
                        nxt_s.nv_store = 1'b1;
                    end
                    nxt_s.prog = pwdata[`CTAO_B_PROG];
                end
                `CTAO_A_SETUP: begin
                    if (!s_ff.prog) begin
                        err = `CTAO_ERR_NOW;
                    end else begin
                        nxt_s.teach = pwdata[`CTAO_B_TEACH];
                        nxt_s.enc_lin = pwdata[`CTAO_B_ENC];
                        if (pwdata[`CTAO_B_TEACH] != s_ff.teach || pwdata[`CTAO_B_ENC] != s_ff.enc_lin) begin
                            nxt_s.store_pend = 1'b1;
                        end
                        ev[`CTAO_EV_DONE] = 1'b1;
                    end
                end
                `CTAO_A_CMD: begin
                    unique case (pwdata[`CTAO_F_CMD])
                        `CTAO_CMD_CM: begin
                            if (s_ff.wcnt == '0) begin
                                err = `CTAO_ERR_EMPTY;
                            end else begin
                                nxt_s.bufm = s_ff.wrk;
                                nxt_s.bcnt = s_ff.wcnt;
                                ev[`CTAO_EV_DONE] = 1'b1;
                            end
                        end
                        `CTAO_CMD_WM: begin
                            nxt_s.bcnt = '0;
                            ev[`CTAO_EV_DONE] = 1'b1;
                        end
                        `CTAO_CMD_APPEND: begin
                            if (s_ff.bcnt == `CTAO_DEPTH_CNT) begin
                                err = `CTAO_ERR_MEM;
                            end else if (is_ana && !pct_ok) begin
                                err = `CTAO_ERR_DATA;
                            end else if (is_tout && s_ff.tmr_en[ent.out[2:0] - 3'h1] && ent.cam != '0) begin
                                err = `CTAO_ERR_MULTI;
                            end else begin
                                nxt_s.bufm[s_ff.bcnt[3:0]] = ent;
                                // Percent kept only on analog channels
                                nxt_s.bufm[s_ff.bcnt[3:0]].pct = is_ana ? ent.pct : '0;
                                nxt_s.bcnt = s_ff.bcnt + 5'h1;
                                ev[`CTAO_EV_DONE] = 1'b1;
                            end
                        end
                        `CTAO_CMD_SAVE: begin
                            if (s_ff.bcnt == '0) begin
                                err = `CTAO_ERR_BUF_EMPTY;
                            end else begin
                                nxt_s.wrk = s_ff.bufm;
                                nxt_s.wcnt = s_ff.bcnt;
                                ev[`CTAO_EV_DONE] = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
                `CTAO_A_ENTRY_A: nxt_s.ent_a = pwdata;
                `CTAO_A_ENTRY_P: nxt_s.ent_p = pwdata[`CTAO_F_PCT];
                `CTAO_A_RD_IDX: nxt_s.rd_idx = pwdata[`CTAO_F_RD_IDX];
                `CTAO_A_TIMER: begin
                    nxt_s.tmr_sel = pwdata[`CTAO_F_TMR_IDX];
                    if (!s_ff.prog) begin
                        err = `CTAO_ERR_NOW;
                    end else if (pwdata[`CTAO_B_TMR_EN] && (mult < `CTAO_TMR_MIN || mult > `CTAO_TMR_MAX)) begin
                        err = `CTAO_ERR_DATA;
                    end else begin
                        nxt_s.tmr_en[pwdata[`CTAO_F_TMR_IDX]] = pwdata[`CTAO_B_TMR_EN];
                        nxt_s.tmr_mult[pwdata[`CTAO_F_TMR_IDX]] = mult;
                        nxt_s.store_pend = 1'b1;
                        ev[`CTAO_EV_DONE] = 1'b1;
                    end
                end
                `CTAO_A_HOLD0: nxt_s.hoff[3:0] = pwdata;
                `CTAO_A_HOLD1: nxt_s.hoff[5:4] = pwdata[`CTAO_F_HOLD1];
                `CTAO_A_TX: begin
                    nxt_s.tx_ch = pwdata[`CTAO_F_CHAR];
                    nxt_s.tx_data = pwdata[`CTAO_F_CHAR];
                    nxt_s.tx_valid = 1'b1;
                    nxt_s.tx_st = ctao_pkg::TX_ECHO;
                end
                `CTAO_A_IRQ_EN: nxt_s.irq_en = pwdata[`CTAO_F_IRQ];
                `CTAO_A_IRQ_CLR: clr = pwdata[`CTAO_F_IRQ];
                default: ;
            endcase
        end
        if (err != `CTAO_ERR_NONE) begin
            ev[`CTAO_EV_ERR] = 1'b1;
        end
        if (ev[`CTAO_EV_DONE] || ev[`CTAO_EV_ERR]) begin
            nxt_s.err_code = err;
        end
        // Set wins over a clear in the same cycle
        nxt_s.irq_st = (s_ff.irq_st & ~clr) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.teach <= `CTAO_TEACH_RST;
            s_ff.enc_lin <= `CTAO_ENC_RST;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign sw_out = s_ff.sw_out;
    assign tx_data = s_ff.tx_data;
    assign tx_valid = s_ff.tx_valid;
    assign teach_en = s_ff.teach;
    assign enc_linear = s_ff.enc_lin;
    assign store_led = s_ff.store_pend;
    assign nv_store = s_ff.nv_store;
    assign irq = |(s_ff.irq_st & s_ff.irq_en);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic cmd_wr;
    assign cmd_wr = wr && paddr == `CTAO_A_CMD;

    sequence s_cm_empty;
        cmd_wr && pwdata[`CTAO_F_CMD] == `CTAO_CMD_CM && s_ff.wcnt == '0;
    endsequence
    sequence s_cm_full;
        cmd_wr && pwdata[`CTAO_F_CMD] == `CTAO_CMD_CM && s_ff.wcnt != '0;
    endsequence
    sequence s_lf_sent;
        ce && s_ff.tx_st == ctao_pkg::TX_ECHO && tx_ready && tx_data == `CTAO_CH_LF;
    endsequence
    sequence s_timer_fall;
        ce && s_ff.win_q[0] && !cam_win[0] && s_ff.tmr_en[0];
    endsequence

    logic irq_st_err;
    assign irq_st_err = s_ff.irq_st[`CTAO_EV_ERR];
    property p_cm_empty;
        s_cm_empty |=> s_ff.err_code == `CTAO_ERR_EMPTY && irq_st_err;
    endproperty
    a_cm_empty: assert property (p_cm_empty) else $error("empty completion not refused");

    property p_cm_copy;
        s_cm_full |=> s_ff.bcnt == $past(s_ff.wcnt) && s_ff.bufm == $past(s_ff.wrk);
    endproperty
    a_cm_copy: assert property (p_cm_copy) else $error("completion did not copy");

    property p_pct_range;
        cmd_wr && pwdata[`CTAO_F_CMD] == `CTAO_CMD_APPEND && is_ana && !pct_ok |=> $stable(s_ff.bcnt);
    endproperty
    a_pct_range: assert property (p_pct_range) else $error("bad percent accepted");

    property p_multi_timer;
        // Full buffer is reported ahead of the cam check
        cmd_wr && pwdata[`CTAO_F_CMD] == `CTAO_CMD_APPEND && is_tout && ent.cam != '0
            && s_ff.tmr_en[ent.out[2:0] - 3'h1] && s_ff.bcnt != `CTAO_DEPTH_CNT
            |=> s_ff.err_code == `CTAO_ERR_MULTI && $stable(s_ff.bcnt);
    endproperty
    a_multi_timer: assert property (p_multi_timer) else $error("multi cam on timer output");

    property p_tmr_limit;
        wr && paddr == `CTAO_A_TIMER && pwdata[`CTAO_B_TMR_EN] && (mult < `CTAO_TMR_MIN || mult > `CTAO_TMR_MAX)
            |=> $stable(s_ff.tmr_mult) && $stable(s_ff.tmr_en);
    endproperty
    a_tmr_limit: assert property (p_tmr_limit) else $error("timer multiplier out of range taken");

    property p_setup_lock;
        wr && paddr == `CTAO_A_SETUP && !s_ff.prog |=> $stable(teach_en) && $stable(enc_linear);
    endproperty
    a_setup_lock: assert property (p_setup_lock) else $error("setup changed outside program mode");

    property p_store_led;
        wr && paddr == `CTAO_A_SETUP && s_ff.prog && pwdata[`CTAO_B_ENC] != enc_linear |=> store_led;
    endproperty
    a_store_led: assert property (p_store_led) else $error("store flag not lit");

    property p_ok_line;
        s_lf_sent |=> tx_valid && tx_data == `CTAO_CH_O && s_ff.tx_st == ctao_pkg::TX_OK;
    endproperty
    a_ok_line: assert property (p_ok_line) else $error("no OK after echoed line");

    property p_timer_hold;
        s_timer_fall |=> sw_out[0] && s_ff.hold[0];
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer output dropped at window end");

    property p_timer_only8;
        wr && paddr == `CTAO_A_TIMER |=> s_ff.tmr_sel == $past(pwdata[`CTAO_F_TMR_IDX]);
    endproperty
    a_timer_only8: assert property (p_timer_only8) else $error("timer select wrong");
endmodule : ctao_top

// ===== verification/ctao_sink.sv
module ctao_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    integer seed = 32'h00005a5a;
    // Random stalls, so the echo must hold each character
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                rx_q.push_back(tx_data);
            end
            tx_ready <= ($random(seed) & 3) != 0;
        end
    end
endmodule : ctao_sink

// ===== verification/ctao_tb.sv
`include "ctao_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pslverr, pready, tx_valid, tx_ready, teach_en, enc_linear, store_led, nv_store, irq;
    logic lerr;
    logic [7:0] paddr, cam_win, sw_out, tx_data, pv, lastp;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] ex[$];
    logic [13:0] tm[4] = '{14'h0000, 14'h2710, 14'h270f, 14'h0003};
    logic [7:0] te[4] = '{`CTAO_ERR_DATA, `CTAO_ERR_DATA, 8'h00, 8'h00};
    logic [7:0] pc[4] = '{8'h9c, 8'h64, 8'h9b, 8'h65};
    integer seed = 32'ha8c3d89a;
    int bad_count = 0;
    int samples_checked = 0;
    int nv_seen = 0;
    int i, n, n1, na;
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        if (nv_store === 1'b1) nv_seen <= nv_seen + 1;
    end
    // Short tick keeps the timer run brief
    ctao_top #(.TICK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cam_win(cam_win), .sw_out(sw_out), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .teach_en(teach_en), .enc_linear(enc_linear), .store_led(store_led), .nv_store(nv_store), .irq(irq));
    ctao_sink snk (.pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic close_out;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here; the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic cmd(input logic [2:0] c);
        wr(`CTAO_A_CMD, 32'(c));
        rd(`CTAO_A_CMD);
    endtask : cmd
    task automatic ent(input logic [5:0] o, input logic [3:0] c, input logic [7:0] p);
        wr(`CTAO_A_ENTRY_A, {11'h020, 11'h010, c, o});
        wr(`CTAO_A_ENTRY_P, 32'(p));
        cmd(`CTAO_CMD_APPEND);
    endtask : ent
    function automatic logic [7:0] pcode(input logic [7:0] p);
        return ($signed(p) >= -100 && $signed(p) <= 100) ? 8'h00 : `CTAO_ERR_DATA;
    endfunction : pcode
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cam_win = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({teach_en, enc_linear}), 32'h2);
        rd(`CTAO_A_SETUP); chk(rdv, 32'h1);
        rd(`CTAO_A_LINK); chk(rdv, `CTAO_LINK_CFG);
        wr(`CTAO_A_SETUP, 32'h2); rd(`CTAO_A_CMD); chk(rdv & 32'hff, 32'(`CTAO_ERR_NOW));
        rd(`CTAO_A_SETUP); chk(rdv, 32'h1);
        wr(`CTAO_A_CTRL, 32'h1);
        cmd(`CTAO_CMD_CM); chk(rdv & 32'hff, 32'h70);
        wr(`CTAO_A_SETUP, 32'h2); rd(`CTAO_A_SETUP); chk(rdv, 32'h102);
        chk(32'({teach_en, enc_linear, store_led}), 32'h3);
        cmd(`CTAO_CMD_WM);
        na = 0;
        for (i = 0; i < 12; i++) begin
            pv = (i < 4) ? pc[i] : 8'($random(seed));
            ent(6'(51 + i % 4), 4'(i / 4 + 1), pv);
            chk(rdv & 32'hff, 32'(pcode(pv)));
            if (pcode(pv) == 8'h00) begin
                na++;
                lastp = pv;
            end
        end
        cmd(`CTAO_CMD_SAVE);
        cmd(`CTAO_CMD_CM); chk(rdv & 32'hff, 32'h0);
        rd(`CTAO_A_COUNT); chk(rdv, 32'((na << 8) | na));
        wr(`CTAO_A_RD_IDX, 32'(16 + na - 1)); rd(`CTAO_A_RD_P); chk(rdv, {{24{lastp[7]}}, lastp});
        for (i = na; i <= 16; i++) begin
            ent(6'(20 + i), 4'h0, 8'h00);
            chk(rdv & 32'hff, (i < 16) ? 32'h0 : 32'(`CTAO_ERR_MEM));
        end
        wr(`CTAO_A_HOLD0, 32'h00170064); rd(`CTAO_A_HOLD0); chk(rdv, 32'h00170064);
        wr(`CTAO_A_HOLD1, 32'habcd00ff); rd(`CTAO_A_HOLD1); chk(rdv, 32'h000000ff);
        for (i = 0; i < 4; i++) begin
            wr(`CTAO_A_TIMER, {11'h0, 1'b1, 1'b0, 3'h0, 2'h0, tm[i]});
            rd(`CTAO_A_CMD); chk(rdv & 32'hff, 32'(te[i]));
        end
        rd(`CTAO_A_TIMER); chk(rdv, 32'h00100003);
        // Empty buffer, so the cam check and not the depth check answers
        cmd(`CTAO_CMD_WM);
        ent(6'h01, 4'h2, 8'h00); chk(rdv & 32'hff, 32'(`CTAO_ERR_MULTI));
        rd(`CTAO_A_IRQ_ST); chk(rdv, 32'h3);
        wr(`CTAO_A_IRQ_CLR, 32'hf);
        wr(`CTAO_A_IRQ_EN, 32'h4);
        wr(`CTAO_A_CTRL, 32'h0);
        rd(`CTAO_A_SETUP); chk(rdv, 32'h2);
        chk(32'(nv_seen), 32'h1);
        chk(32'(irq), 32'h0);
        cam_win <= 8'h03;
        repeat (3) @(posedge pclk);
        cam_win <= 8'h00;
        n = 0;
        n1 = 0;
        do begin
            @(posedge pclk);
            n++;
            if (sw_out[1] !== 1'b0) n1 = n;
        end while (sw_out[0] === 1'b1 && n < 100);
        chk(32'(n >= 16 && n <= 28), 32'h1);
        chk(32'(n1), 32'h1);
        @(negedge pclk); chk(32'(irq), 32'h1);
        wr(`CTAO_A_IRQ_CLR, 32'h4);
        @(negedge pclk); chk(32'(irq), 32'h0);
        rd(8'h80); chk({lerr, rdv[30:0]}, 32'h80000000);
        // Clock enable low freezes state and stalls the bus
        ce <= 1'b0;
        cam_win <= 8'h04;
        repeat (3) @(posedge pclk);
        chk(32'({pready, sw_out}), 32'h0);
        ce <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'(sw_out), 32'h4);
        cam_win <= 8'h00;
        // Chars from 0x40 up never start the OK tail
        ex = '{8'h0a, `CTAO_CH_O, `CTAO_CH_K, `CTAO_CH_CR, `CTAO_CH_LF, `CTAO_CH_ETX, `CTAO_CH_ETX};
        wr(`CTAO_A_TX, 32'h0a);
        wr(`CTAO_A_TX, 32'h03);
        for (i = 0; i < 3; i++) begin
            pv = 8'h40 | 8'($random(seed) & 31);
            ex.push_back(pv);
            wr(`CTAO_A_TX, 32'(pv));
        end
        n = 0;
        while (snk.rx_q.size() < ex.size() && n < 500) begin
            @(posedge pclk);
            n++;
        end
        foreach (ex[k]) chk(32'(snk.rx_q[k]), 32'(ex[k]));
        close_out();
    end
endmodule : testbench
